// [hw/otm_mode_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_mode_ctrl #(
  parameter int FIFO_DEPTH = otm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Write path origin: high when the serial interface made this write
  input wire logic avs_from_serial,
  // Internal source words for the program port
  input wire otm_pkg::otm_src_t src_words,
  // DMA feed into the FIFO
  input wire logic dma_in_valid,
  output logic dma_in_ready,
  input wire logic [31:0] dma_in_data,
  // Macrocell side: programming word stream
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [31:0] prog_data,
  // Macrocell side: controls
  output otm_pkg::otm_cfg_t cfg,
  output logic fast_timing,
  output logic read_strobe,
  output logic dma_active,
  output logic [31:0] program_port,
  output logic busy
);
  // The status level field and the FIFO pointers need at least two entries
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("otm_mode_ctrl: FIFO_DEPTH too small");
  end

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  otm_pkg::otm_cfg_t cfg_q;
  logic flush_q;
  logic [otm_pkg::WCOUNT_W-1:0] wcount_q;
  logic [otm_pkg::WCOUNT_W-1:0] remain_q;
  logic single_done_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] port_q;
  logic wr_mode;
  logic wr_fifo;
  logic wr_wc;
  logic is_auto_program;
  logic is_auto;
  logic use_port;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [31:0] wmask;

  // One wait cycle per access, then acknowledge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) ack_q <= 1'b0;
    else ack_q <= (avs_read || avs_write) && !ack_q;
  end

  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_mode = avs_write && ack_q && (avs_address == otm_pkg::MODE_ADDR);
  assign wr_fifo = avs_write && ack_q && (avs_address == otm_pkg::FIFO_PORT_ADDR);
  assign wr_wc = avs_write && ack_q && (avs_address == otm_pkg::WCOUNT_ADDR);

  // Mode register; only defined fields are stored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q <= '0;
    end else if (wr_mode) begin
      if (avs_byteenable[0]) begin
        cfg_q.operating_mode_field <= avs_writedata[otm_pkg::MODE_LSB +: 3];
        cfg_q.dma_transfer_enable <= avs_writedata[otm_pkg::DMA_BIT] && !avs_from_serial;
        cfg_q.two_cycle_read <= avs_writedata[otm_pkg::TWO_CYC_BIT];
        cfg_q.program_source_select <= avs_writedata[otm_pkg::SRC_SEL_BIT];
      end
      if (avs_byteenable[1]) cfg_q.fast_program_timing <= avs_writedata[otm_pkg::FAST_BIT];
      if (avs_byteenable[3]) cfg_q.program_source_mux <= avs_writedata[otm_pkg::MUX_LSB +: 2];
    end
  end

  // Flush is a pulse: set by the write, cleared the next cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) flush_q <= 1'b0;
    else flush_q <= wr_mode && avs_byteenable[0] && avs_writedata[otm_pkg::FLUSH_BIT];
  end

  // Word count setting
  always_ff @(posedge clk_sys) begin
    if (sys_rst) wcount_q <= '0;
    else if (wr_wc) wcount_q <= (avs_writedata[otm_pkg::WCOUNT_W-1:0] & wmask[otm_pkg::WCOUNT_W-1:0])
                              | (wcount_q & ~wmask[otm_pkg::WCOUNT_W-1:0]);
  end

  assign is_auto_program = (cfg_q.operating_mode_field == otm_pkg::OTM_AUTO_PROGRAM);
  assign is_auto = is_auto_program || (cfg_q.operating_mode_field == otm_pkg::OTM_AUTO_READ);
  assign use_port = is_auto_program && cfg_q.program_source_select;

  // Program port source mux, zero-padded per source
  always_comb begin
    unique case (cfg_q.program_source_mux)
      2'h0: port_q = {16'h0000, src_words.reference_trim};
      2'h1: port_q = {src_words.rssi_comp, 8'h00, src_words.rfio_ctrl};
      2'h2: port_q = {3'h0, src_words.lna_ctrl3, src_words.lna_ctrl2, src_words.lna_ctrl1};
      2'h3: port_q = {28'h0000000, src_words.oscillator_trim};
    endcase
  end

  // DMA runs only in auto modes and never with the port source
  assign dma_active = is_auto && cfg_q.dma_transfer_enable && !use_port;

  // FIFO fill: DMA or software port, never both
  assign fifo_in_valid = dma_active ? dma_in_valid : wr_fifo;
  assign fifo_in_data = dma_active ? dma_in_data : avs_writedata;
  assign dma_in_ready = dma_active && fifo_in_ready;

  otm_fifo #(
    .WIDTH(otm_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_otm_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(flush_q),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Remaining words to program; reloaded whenever auto program is entered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      remain_q <= '0;
      single_done_q <= 1'b0;
    end else if (!is_auto_program) begin
      remain_q <= wcount_q;
      single_done_q <= 1'b0;
    end else if (prog_valid && prog_ready) begin
      if (use_port) single_done_q <= 1'b1;
      else remain_q <= remain_q - 1'b1;
    end
  end

  // Programming stream: single port word, or FIFO words up to the count
  always_comb begin
    if (use_port) begin
      prog_valid = !single_done_q;
      prog_data = port_q;
    end else begin
      prog_valid = is_auto_program && (remain_q != '0) && fifo_out_valid;
      prog_data = fifo_out_data;
    end
  end
  assign fifo_out_ready = !use_port && is_auto_program && (remain_q != '0) && prog_ready;

  // Read data mux; reserved bits return zero
  always_comb begin
    rdata_q = '0;
    unique case (avs_address)
      otm_pkg::MODE_ADDR: begin
        rdata_q[otm_pkg::MODE_LSB +: 3] = cfg_q.operating_mode_field;
        rdata_q[otm_pkg::DMA_BIT] = cfg_q.dma_transfer_enable;
        rdata_q[otm_pkg::TWO_CYC_BIT] = cfg_q.two_cycle_read;
        rdata_q[otm_pkg::SRC_SEL_BIT] = cfg_q.program_source_select;
        rdata_q[otm_pkg::FAST_BIT] = cfg_q.fast_program_timing;
        rdata_q[otm_pkg::MUX_LSB +: 2] = cfg_q.program_source_mux;
      end
      otm_pkg::WCOUNT_ADDR: rdata_q[otm_pkg::WCOUNT_W-1:0] = wcount_q;
      otm_pkg::STATUS_ADDR: begin
        rdata_q[otm_pkg::WCOUNT_W-1:0] = remain_q;
        rdata_q[otm_pkg::LEVEL_LSB +: LW] = fifo_level;
      end
      default: rdata_q = '0;
    endcase
  end

  // Registered read data, captured during the wait cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) avs_readdata <= '0;
    else if (avs_read && !ack_q) avs_readdata <= rdata_q;
  end

  // Registered control outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg <= '0;
      fast_timing <= 1'b0;
      program_port <= '0;
      busy <= 1'b0;
    end else begin
      cfg <= cfg_q;
      fast_timing <= cfg_q.fast_program_timing;
      program_port <= port_q;
      busy <= cfg_q.operating_mode_field != otm_pkg::OTM_IDLE_STANDBY;
    end
  end

  otm_rate u_otm_rate (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .active((cfg_q.operating_mode_field == otm_pkg::OTM_MANUAL_READ) ||
            (cfg_q.operating_mode_field == otm_pkg::OTM_AUTO_READ)),
    .two_cycle(cfg_q.two_cycle_read),
    .strobe(read_strobe)
  );
endmodule : otm_mode_ctrl
`default_nettype wire

// [hw/otm_pkg.sv]
// Summary of operation
// - The mode field in bits 2:0 selects standby, manual read, manual program, auto read or auto program; codes 101 to 111 are reserved test modes.
// - Bit 8 selects normal (0) or fast (1) timing for every programming activity, including write recovery.
// - Bits 29:28 choose which of four zero-padded internal 32-bit source words drives the program input port.
// - In auto program mode with the source select at 0, data comes from the FIFO for the number of words in the word count.
// - With the source select at 1, exactly one word is programmed from the program input port; the DMA bit, word count and FIFO are ignored.
// - The alternative program source takes effect only in auto program mode.
// - Each macrocell read fetches 16 bits, once every cycle with bit 6 at 0 and once every two cycles with bit 6 at 1.
// - Writing 1 to the flush bit empties the FIFO and the bit then returns to 0 by itself.
// - The DMA bit applies only in auto read or auto program mode and selects whether DMA moves the data.
// - With the DMA bit at 1, the controller moves data from memory into the FIFO through the DMA feed by itself; nothing is moved back to memory.
// - A mode register write that comes through the serial interface forces the DMA bit to 0.
// - In auto program mode with the source select set, the DMA engine stays inactive whatever the DMA bit says.
package otm_pkg;

  // Register map (byte addresses)
  localparam logic [31:0] MODE_ADDR = 32'h4000_8000;
  localparam logic [31:0] FIFO_PORT_ADDR = 32'h4000_8010;
  localparam logic [31:0] WCOUNT_ADDR = 32'h4000_8014;
  localparam logic [31:0] STATUS_ADDR = 32'h4000_8018;

  // Mode register field positions
  localparam int MODE_LSB = 0;
  localparam int DMA_BIT = 4;
  localparam int FLUSH_BIT = 5;
  localparam int TWO_CYC_BIT = 6;
  localparam int SRC_SEL_BIT = 7;
  localparam int FAST_BIT = 8;
  localparam int MUX_LSB = 28;
  localparam int LEVEL_LSB = 16; // Status fill level field
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  localparam int WCOUNT_W = 13;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    OTM_IDLE_STANDBY = 3'h0,
    OTM_MANUAL_READ = 3'h1,
    OTM_MANUAL_PROGRAM = 3'h2,
    OTM_AUTO_READ = 3'h3,
    OTM_AUTO_PROGRAM = 3'h4
  } otm_mode_t;

  typedef struct packed {
    logic [1:0] program_source_mux;
    logic fast_program_timing;
    logic program_source_select;
    logic two_cycle_read;
    logic dma_transfer_enable;
    logic [2:0] operating_mode_field;
  } otm_cfg_t;

  // Internal source words feeding the program port mux
  typedef struct packed {
    logic [15:0] reference_trim;
    logic [15:0] rssi_comp;
    logic [7:0] rfio_ctrl;
    logic [4:0] lna_ctrl3;
    logic [11:0] lna_ctrl2;
    logic [11:0] lna_ctrl1;
    logic [3:0] oscillator_trim;
  } otm_src_t;

endpackage : otm_pkg

// [hw/otm_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("otm_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full and empty from the extra pointer bit
  assign level = wr_q - rd_q;
  assign in_ready = (level != DEPTH[AW:0]) && !flush;
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  // Pointers; flush drops everything at once
  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage needs no reset; empty words are never presented
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : otm_fifo
`default_nettype wire

// [hw/otm_rate.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_rate (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic active,
  input wire logic two_cycle,
  // One-cycle read strobe
  output logic strobe
);
  logic phase_q;

  // Alternating phase halves the read rate when asked
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !active) phase_q <= 1'b0;
    else phase_q <= two_cycle ? !phase_q : 1'b0;
  end

  assign strobe = active && (!two_cycle || phase_q);
endmodule : otm_rate
`default_nettype wire

// [tb/otm_mode_ctrl_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_mode_ctrl_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic avs_from_serial,
  // Controls
  input wire otm_pkg::otm_cfg_t cfg,
  input wire logic read_strobe,
  input wire logic dma_active,
  input wire logic dma_in_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rd;
  logic dma_ok;
  logic mwr;
  logic wd_fast;
  // cfg lags the live fields by one cycle, so outputs are judged one cycle back
  assign rd = cfg.operating_mode_field inside {3'h1, 3'h3};
  assign dma_ok = cfg.dma_transfer_enable && (cfg.operating_mode_field == 3'h3 ||
    (cfg.operating_mode_field == 3'h4 && !cfg.program_source_select));
  assign mwr = avs_write && !avs_waitrequest && avs_address == otm_pkg::MODE_ADDR;
  assign wd_fast = avs_writedata[8];
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd1;
    rd && !cfg.two_cycle_read;
  endsequence
  sequence s_rd2;
    rd && cfg.two_cycle_read;
  endsequence
  a_wait_one: assert property (s_req |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  a_strobe_off: assert property (!rd |-> $past(!read_strobe))
    else $error("read strobe outside read modes");
  a_strobe_full: assert property (s_rd1 ##1 s_rd1 |-> $past(read_strobe))
    else $error("strobe missing in one cycle access");
  a_strobe_half: assert property (s_rd2 [*3] |-> $past(read_strobe) != $past(read_strobe, 2))
    else $error("strobe not alternating in two cycle access");
  a_dma_gate: assert property (!dma_ok |-> $past(!dma_active))
    else $error("dma active when not allowed");
  a_ready_gate: assert property (dma_in_ready |-> dma_active)
    else $error("dma ready without dma");
  a_serial_dma: assert property (mwr && avs_from_serial && avs_byteenable[0]
    |-> ##2 !cfg.dma_transfer_enable)
    else $error("serial write left dma on");
  a_mode_write: assert property (mwr && avs_byteenable[0]
    |-> ##2 cfg.operating_mode_field == 3'($past(avs_writedata, 2)))
    else $error("mode field not written");
  a_fast_write: assert property (mwr && avs_byteenable[1]
    |-> ##2 cfg.fast_program_timing == $past(wd_fast, 2))
    else $error("fast timing bit not written");
  a_mux_write: assert property (mwr && avs_byteenable[3]
    |-> ##2 cfg.program_source_mux == 2'($past(avs_writedata, 2) >> 28))
    else $error("mux field not written");
endmodule : otm_mode_ctrl_chk
bind otm_mode_ctrl otm_mode_ctrl_chk u_otm_mode_ctrl_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .avs_from_serial(avs_from_serial), .cfg(cfg),
  .read_strobe(read_strobe), .dma_active(dma_active), .dma_in_ready(dma_in_ready));
`default_nettype wire

// [tb/otm_cell_model.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_cell_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Programming stream
  input wire logic prog_valid,
  output logic prog_ready,
  input wire logic [31:0] prog_data,
  // DMA feed
  output logic dma_in_valid,
  input wire logic dma_in_ready,
  output logic [31:0] dma_in_data
);
  logic [31:0] got[$];
  logic [31:0] seq_q = 32'h0;
  // Random stalls, so the design must hold each word until it is taken
  always @(posedge clk_sys) begin
    prog_ready <= !sys_rst && 1'($urandom_range(1));
    if (prog_valid && prog_ready) got.push_back(prog_data);
  end
  // Memory side of the DMA: a counting stream, held until accepted
  always @(posedge clk_sys) begin
    dma_in_valid <= !sys_rst;
    if (sys_rst) seq_q <= 32'h0;
    else if (dma_in_valid && dma_in_ready) seq_q <= seq_q + 32'h1;
  end
  // Idle data is the inverted count so stale values are never mistaken for words
  assign dma_in_data = dma_in_valid ? 32'hd000_0000 + seq_q : ~seq_q;
endmodule : otm_cell_model
`default_nettype wire

// [tb/otm_mode_ctrl_test.sv]
`timescale 1ns/10ps
`default_nettype none
module otm_mode_ctrl_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_from_serial = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_address = 32'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, prog_data, dma_in_data;
  logic avs_waitrequest, prog_valid, prog_ready, dma_in_valid, dma_in_ready;
  logic read_strobe, dma_active, fast_timing, busy;
  logic [31:0] program_port;
  otm_pkg::otm_src_t src_words = '0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] exp[$];
  otm_mode_ctrl u_otm_mode_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_from_serial(avs_from_serial), .src_words(src_words), .dma_in_valid(dma_in_valid),
    .dma_in_ready(dma_in_ready), .dma_in_data(dma_in_data), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_data(prog_data), .cfg(), .fast_timing(fast_timing),
    .read_strobe(read_strobe), .dma_active(dma_active), .program_port(program_port),
    .busy(busy));
  otm_cell_model u_otm_cell_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data),
    .dma_in_valid(dma_in_valid), .dma_in_ready(dma_in_ready), .dma_in_data(dma_in_data));
  // System clock and a hang guard far above the run length
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a, d, input logic s,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_from_serial <= s;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] t;
    bus(1'b1, a, d, 1'b0, t);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 1'b0, q);
  endtask : rd
  task automatic wm(input logic [31:0] d);
    wr(otm_pkg::MODE_ADDR, d);
  endtask : wm
  task automatic wait_got(input int n);
    while (u_otm_cell_model.got.size() < n) @(posedge clk_sys);
  endtask : wait_got
  // Expected program port word for each mux code
  function automatic logic [31:0] pw(input logic [1:0] m);
    case (m)
      2'h0: return {16'h0, src_words.reference_trim};
      2'h1: return {src_words.rssi_comp, 8'h0, src_words.rfio_ctrl};
      2'h2: return {3'h0, src_words.lna_ctrl3, src_words.lna_ctrl2, src_words.lna_ctrl1};
      default: return {28'h0, src_words.oscillator_trim};
    endcase
  endfunction : pw
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    logic [31:0] q;
    logic [31:0] w;
    int c;
    void'($urandom(32'he602));
    src_words <= 73'({$urandom, $urandom, $urandom});
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(otm_pkg::MODE_ADDR, q);
    chk(q, 32'h0);
    rd(32'h4000_8020, q);
    chk(q, 32'h0);
    // Each mode with random fields except DMA and flush, reserved bits random
    for (int k = 0; k < 5; k++) begin
      w = ($urandom & 32'hffff_ffc8) | k;
      wm(32'h0);
      wm(w);
      rd(otm_pkg::MODE_ADDR, q);
      chk(q, w & 32'h3000_01d7);
      chk(fast_timing, w[otm_pkg::FAST_BIT]);
      chk(busy, k != 0);
    end
    // Strobe rate: manual read single cycle, auto read two cycle
    for (int k = 0; k < 2; k++) begin
      wm(32'h0);
      wm(k ? 32'h43 : 32'h1);
      repeat (3) @(posedge clk_sys);
      c = 0;
      repeat (20) begin
        @(posedge clk_sys);
        c += read_strobe;
      end
      chk(c, k ? 10 : 20);
    end
    wm(32'h0);
    bus(1'b1, otm_pkg::MODE_ADDR, 32'h13, 1'b1, q);
    rd(otm_pkg::MODE_ADDR, q);
    chk(q, 32'h3);
    // Flush empties the FIFO and the bit reads back as zero
    wr(otm_pkg::FIFO_PORT_ADDR, 32'h1234_5678);
    wm(32'h20);
    rd(otm_pkg::STATUS_ADDR, q);
    chk(q >> 16, 32'h0);
    rd(otm_pkg::MODE_ADDR, q);
    chk(q, 32'h0);
    // Fill past full, then program everything out under stalls
    for (int k = 0; k < 17; k++) begin
      w = $urandom;
      wr(otm_pkg::FIFO_PORT_ADDR, w);
      if (k < 16) exp.push_back(w);
    end
    rd(otm_pkg::STATUS_ADDR, q);
    chk(q >> 16, 32'h10);
    wr(otm_pkg::WCOUNT_ADDR, 32'h10);
    u_otm_cell_model.got.delete();
    wm(32'h4);
    wait_got(16);
    foreach (exp[i]) chk(u_otm_cell_model.got[i], exp[i]);
    // One port word per mux code, DMA bit and FIFO ignored
    wm(32'h0);
    wr(otm_pkg::FIFO_PORT_ADDR, 32'h5a5a_5a5a);
    for (int k = 0; k < 4; k++) begin
      u_otm_cell_model.got.delete();
      wm(32'h0);
      wm((k << 28) | 32'h94);
      wait_got(1);
      repeat (8) @(posedge clk_sys);
      chk(u_otm_cell_model.got.size(), 1);
      chk(u_otm_cell_model.got[0], pw(2'(k)));
      chk(program_port, pw(2'(k)));
      chk(dma_active, 1'b0);
    end
    rd(otm_pkg::STATUS_ADDR, q);
    chk(q >> 16, 32'h1);
    // Port source selected outside auto program does nothing
    u_otm_cell_model.got.delete();
    wm(32'h0);
    wm(32'h82);
    repeat (8) @(posedge clk_sys);
    chk(u_otm_cell_model.got.size(), 0);
    // DMA feeds the FIFO in auto program mode; the count stops the stream
    wm(32'h20);
    wr(otm_pkg::WCOUNT_ADDR, 32'h3);
    u_otm_cell_model.got.delete();
    wm(32'h14);
    wait_got(3);
    chk(dma_active, 1'b1);
    repeat (8) @(posedge clk_sys);
    chk(u_otm_cell_model.got.size(), 3);
    for (int i = 0; i < 3; i++) chk(u_otm_cell_model.got[i], 32'hd000_0000 + i);
    wm(32'h0);
    test_done();
  end
endmodule : otm_mode_ctrl_test
`default_nettype wire
